// ---- shared/stl_cfg.svh ----
/*
  Constants of the step pulse tape command link: track limits, pulse
  counts and timing counts at the 25 MHz system clock.
  Assumes both ends share one clock and include this header by name.
*/
`ifndef STL_CFG_SVH
`define STL_CFG_SVH

`define STL_CLK_HZ        25000000
`define STL_MS_CYC        (`STL_CLK_HZ / 1000)
`define STL_TRK_W         7
`define STL_TMR_W         20
`define STL_MID_TRACK     7'h26
`define STL_MAX_TRACK     7'h4d
`define STL_PAUSE_PULSES  7'h03
`define STL_RECAL_PULSES  7'h01
`define STL_BUSY_MS       13
`define STL_BUSY_CYC      (`STL_BUSY_MS * `STL_MS_CYC)
`define STL_GAP_MS        16
`define STL_GAP_CYC       (`STL_GAP_MS * `STL_MS_CYC)
`define STL_CHK_MARGIN    16
`define STL_ID_BLOCKS     2
`define STL_STEP_MS_RST   4'h3
`define STL_HLOAD_RST     7'h01
`define STL_HUNLOAD_RST   4'h1
`define STL_DMA_RST       1'b1

`endif

// ---- shared/stl_pkg.sv ----
/*
  Types shared by both ends of the step pulse tape command link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package stl_pkg;

  typedef logic [6:0] stl_track_type;

  typedef enum logic [1:0] {
    CK_PLAIN,
    CK_RECAL,
    CK_REPORT
  } stl_kind_type;

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_STEP,
    HS_CHK_BUSY,
    HS_WAIT13,
    HS_ID_WAIT
  } stl_host_state_type;

endpackage

// ---- shared/stl_link_if.sv ----
/*
  The link between the controlling side and the emulating tape drive.
  Assumes one clock domain; all signals are plain levels or one-cycle
  pulses of that clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface stl_link_if;
  logic step;     // Step pulse, one cycle high per step.
  logic dir_in;   // Direction, high when stepping toward higher tracks.
  logic busy;     // Drive busy.
  logic index;    // Index pulse, one per tape block.
  logic rdata;    // Header read data, one cycle per header seen at low speed.
  logic track0;   // Track zero status.
  logic wprot;    // Write protect status.

  modport drive (
    input  step,
    input  dir_in,
    output busy,
    output index,
    output rdata,
    output track0,
    output wprot
  );

  modport ctrl (
    output step,
    output dir_in,
    input  busy,
    input  index,
    input  rdata,
    input  track0,
    input  wprot
  );
endinterface

`default_nettype wire

// ---- rtl/stl_drive.sv ----
/*
  Tape drive end: counts step pulse trains into commands, reports busy,
  passes index, low-speed header data and status lines to the controller.
  Assumes the controller end paces steps closer than the gap time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stl_cfg.svh"

module stl_drive #(
  parameter int GAP_CYC  = `STL_GAP_CYC,
  parameter int BUSY_CYC = `STL_BUSY_CYC
) (
  input  wire logic           CLK_I,        // System clock.
  input  wire logic           RST_I,        // Asynchronous reset.
  stl_link_if.drive           link,         // Link to the controller.
  input  wire logic           HIGH_SPEED_I, // Tape at high speed.
  input  wire logic           BLOCK_MARK_I, // Start of a tape block.
  input  wire logic           HEADER_I,     // Header bit under head.
  input  wire logic           WPROT_I,      // Cartridge protected.
  output logic                CMD_VALID_O,  // Command decoded pulse.
  output stl_pkg::stl_track_type CMD_COUNT_O // Pulses in the command.
);
  import stl_pkg::*;

  logic                  step_q;
  logic                  in_train;
  stl_track_type         count;
  logic [`STL_TMR_W-1:0] gap;
  logic [`STL_TMR_W-1:0] busy_cnt;
  logic                  step_rise;
  logic                  train_end;

  assign step_rise = link.step && !step_q;
  assign train_end = in_train && !step_rise &&
                     (gap == `STL_TMR_W'(GAP_CYC - 1));

  // ==========================================================
  // Pulse train counting
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      step_q      <= 1'b0;
      in_train    <= 1'b0;
      count       <= 7'h00;
      gap         <= '0;
      CMD_VALID_O <= 1'b0;
      CMD_COUNT_O <= 7'h00;
    end else begin
      step_q      <= link.step;
      CMD_VALID_O <= 1'b0;
      if (step_rise) begin
        count    <= in_train ? count + 7'h01 : 7'h01;
        in_train <= 1'b1;
        gap      <= '0;
      end else if (train_end) begin
        in_train    <= 1'b0;
        CMD_VALID_O <= 1'b1;
        CMD_COUNT_O <= count;
      end else if (in_train) begin
        gap <= gap + `STL_TMR_W'(1);
      end
    end
  end

  // ==========================================================
  // Busy time after each command
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      busy_cnt  <= '0;
      link.busy <= 1'b0;
    end else if (train_end) begin
      busy_cnt  <= `STL_TMR_W'(BUSY_CYC - 1);
      link.busy <= 1'b1;
    end else if (busy_cnt != '0) begin
      busy_cnt <= busy_cnt - `STL_TMR_W'(1);
    end else begin
      link.busy <= 1'b0;
    end
  end

  // ==========================================================
  // Status lines and tape signals
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      link.track0 <= 1'b0;
      link.wprot  <= 1'b0;
      link.index  <= 1'b0;
      link.rdata  <= 1'b0;
    end else begin
      if (train_end) begin
        link.track0 <= (count == `STL_RECAL_PULSES);
      end
      link.wprot <= WPROT_I;
      link.index <= BLOCK_MARK_I;
      link.rdata <= HEADER_I && !HIGH_SPEED_I;
    end
  end

endmodule // stl_drive

`default_nettype wire

// ---- rtl/stl_ctrl.sv ----
/*
  Controlling end: issues drive commands as relative seeks while keeping
  a shadow of the controller track, recalibrates, checks busy times,
  positions the tape by ID reads and senses drive status.
  Assumes the drive end on the same clock and user strobes of one cycle
  given only while DONE has not yet been owed.
*/
// Behaviour
// - Keep a shadow of the controller track
// - Command of n pulses seeks shadow plus/minus n
// - Seek targets stay within tracks 0 to 77
// - Add below 38, subtract at or above
// - Slow-speed ID read returns next header
// - Fast-speed ID read times out after two blocks
// - Drive suppresses read data at high speed
// - Count each timeout as two blocks, reissue
// - Recalibrate resynchronises shadow after outside change
// - Check drive goes busy after recalibrate
// - Wait 13 ms then sample busy after report
// - Read track zero and write protect status
// - Program step rate, head times, DMA mode
`timescale 1ns/1ps
`default_nettype none
`include "stl_cfg.svh"

module stl_ctrl #(
  parameter int GAP_CYC  = `STL_GAP_CYC,
  parameter int BUSY_CYC = `STL_BUSY_CYC
) (
  input  wire logic           CLK_I,          // System clock.
  input  wire logic           RST_I,          // Asynchronous reset.
  stl_link_if.ctrl            link,           // Link to the drive.
  input  wire logic           CFG_LOAD_I,     // Load configuration.
  input  wire logic [3:0]     STEP_MS_I,      // Step interval in ms.
  input  wire logic [6:0]     HEAD_LOAD_I,    // Head load time.
  input  wire logic [3:0]     HEAD_UNLOAD_I,  // Head unload time.
  input  wire logic           DMA_MODE_I,     // DMA mode select.
  input  wire logic           CMD_I,          // Send a plain command.
  input  wire logic           REPORT_I,       // Send a report command.
  input  wire stl_pkg::stl_track_type CMD_PULSES_I, // Pulses to send.
  input  wire logic           RECAL_I,        // Recalibrate.
  input  wire logic           EXT_CHANGE_I,   // Track moved elsewhere.
  input  wire logic           ID_READ_I,      // Start an ID read.
  input  wire logic [7:0]     POS_BLOCKS_I,   // Blocks to pass, 0 fine.
  input  wire logic           SENSE_I,        // Sense drive status.
  output logic                DONE_O,         // Operation done pulse.
  output logic                ERR_O,          // Operation failed pulse.
  output logic                BUSY_STAT_O,    // Sampled busy status.
  output logic                TRACK0_O,       // Sensed track zero.
  output logic                WPROT_O,        // Sensed write protect.
  output logic                ID_FOUND_O,     // Header found.
  output logic [7:0]          BLOCKS_O,       // Blocks counted passed.
  output stl_pkg::stl_track_type SHADOW_O,    // Shadow track.
  output logic [6:0]          HEAD_LOAD_O,    // Programmed head load.
  output logic [3:0]          HEAD_UNLOAD_O,  // Programmed head unload.
  output logic                DMA_MODE_O,     // Programmed DMA mode.
  output logic                SYNC_LOST_O     // Shadow not trusted.
);
  import stl_pkg::*;

  stl_host_state_type    state;
  stl_kind_type          kind;
  logic [3:0]            step_ms;
  logic [`STL_TMR_W-1:0] step_cyc;
  logic [`STL_TMR_W-1:0] tmr;
  stl_track_type         left;
  stl_track_type         target;
  stl_track_type         next_target;
  logic                  next_dir_in;
  logic [7:0]            pos_goal;
  logic                  idx_q;
  logic                  idx_cnt;
  logic                  idx_rise;
  logic                  start_cmd;
  logic                  bad_cmd;

  assign step_cyc  = `STL_TMR_W'(step_ms) * `STL_TMR_W'(`STL_MS_CYC);
  assign idx_rise  = link.index && !idx_q;
  assign start_cmd = (state == HS_IDLE) && !CFG_LOAD_I && !RECAL_I &&
                     (CMD_I || REPORT_I);
  assign bad_cmd   = SYNC_LOST_O || (CMD_PULSES_I == 7'h00) ||
                     (CMD_PULSES_I > `STL_MID_TRACK);

  // ==========================================================
  // Seek target from the shadow track
  always_comb begin
    if (SHADOW_O < `STL_MID_TRACK) begin
      next_target = SHADOW_O + CMD_PULSES_I;
      next_dir_in = 1'b1;
    end else begin
      next_target = SHADOW_O - CMD_PULSES_I;
      next_dir_in = 1'b0;
    end
  end

  // ==========================================================
  // Controller configuration
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      step_ms       <= `STL_STEP_MS_RST;
      HEAD_LOAD_O   <= `STL_HLOAD_RST;
      HEAD_UNLOAD_O <= `STL_HUNLOAD_RST;
      DMA_MODE_O    <= `STL_DMA_RST;
    end else if (CFG_LOAD_I && state == HS_IDLE) begin
      step_ms       <= (STEP_MS_I == 4'h0) ? 4'h1 : STEP_MS_I;
      HEAD_LOAD_O   <= HEAD_LOAD_I;
      HEAD_UNLOAD_O <= HEAD_UNLOAD_I;
      DMA_MODE_O    <= DMA_MODE_I;
    end
  end

  // ==========================================================
  // Track agreement flag; a new change wins over a recalibrate.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SYNC_LOST_O <= 1'b0;
    end else if (EXT_CHANGE_I) begin
      SYNC_LOST_O <= 1'b1;
    end else if (RECAL_I && state == HS_IDLE && !CFG_LOAD_I) begin
      SYNC_LOST_O <= 1'b0;
    end
  end

  // ==========================================================
  // Command sequencing
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state       <= HS_IDLE;
      kind        <= CK_PLAIN;
      tmr         <= '0;
      left        <= 7'h00;
      target      <= 7'h00;
      pos_goal    <= 8'h00;
      idx_q       <= 1'b0;
      idx_cnt     <= 1'b0;
      link.step   <= 1'b0;
      link.dir_in <= 1'b0;
      SHADOW_O    <= 7'h00;
      DONE_O      <= 1'b0;
      ERR_O       <= 1'b0;
      BUSY_STAT_O <= 1'b0;
      TRACK0_O    <= 1'b0;
      WPROT_O     <= 1'b0;
      ID_FOUND_O  <= 1'b0;
      BLOCKS_O    <= 8'h00;
    end else begin
      idx_q     <= link.index;
      link.step <= 1'b0;
      DONE_O    <= 1'b0;
      ERR_O     <= 1'b0;
      case (state)
        HS_IDLE: begin
          if (CFG_LOAD_I) begin
            DONE_O <= 1'b1;
          end else if (RECAL_I) begin
            kind        <= CK_RECAL;
            left        <= `STL_RECAL_PULSES;
            target      <= 7'h00;
            link.dir_in <= 1'b0;
            tmr         <= '0;
            state       <= HS_STEP;
          end else if (start_cmd && bad_cmd) begin
            ERR_O  <= 1'b1;
            DONE_O <= 1'b1;
          end else if (start_cmd) begin
            kind        <= REPORT_I ? CK_REPORT : CK_PLAIN;
            left        <= CMD_PULSES_I;
            target      <= next_target;
            link.dir_in <= next_dir_in;
            tmr         <= '0;
            state       <= HS_STEP;
          end else if (ID_READ_I) begin
            pos_goal   <= POS_BLOCKS_I;
            BLOCKS_O   <= 8'h00;
            idx_cnt    <= 1'b0;
            ID_FOUND_O <= 1'b0;
            state      <= HS_ID_WAIT;
          end else if (SENSE_I) begin
            TRACK0_O <= link.track0;
            WPROT_O  <= link.wprot;
            DONE_O   <= 1'b1;
          end
        end
        HS_STEP: begin
          if (tmr != '0) begin
            tmr <= tmr - `STL_TMR_W'(1);
          end else begin
            link.step <= 1'b1;
            left      <= left - 7'h01;
            tmr       <= step_cyc - `STL_TMR_W'(1);
            if (left == 7'h01) begin
              SHADOW_O <= target;
              if (kind == CK_RECAL) begin
                tmr   <= `STL_TMR_W'(GAP_CYC + `STL_CHK_MARGIN);
                state <= HS_CHK_BUSY;
              end else if (kind == CK_REPORT) begin
                tmr   <= `STL_TMR_W'(BUSY_CYC - 1);
                state <= HS_WAIT13;
              end else begin
                DONE_O <= 1'b1;
                state  <= HS_IDLE;
              end
            end
          end
        end
        HS_CHK_BUSY: begin
          if (link.busy) begin
            BUSY_STAT_O <= 1'b1;
            DONE_O      <= 1'b1;
            state       <= HS_IDLE;
          end else if (tmr == '0) begin
            BUSY_STAT_O <= 1'b0;
            ERR_O       <= 1'b1;
            DONE_O      <= 1'b1;
            state       <= HS_IDLE;
          end else begin
            tmr <= tmr - `STL_TMR_W'(1);
          end
        end
        HS_WAIT13: begin
          if (tmr == '0) begin
            BUSY_STAT_O <= link.busy;
            DONE_O      <= 1'b1;
            state       <= HS_IDLE;
          end else begin
            tmr <= tmr - `STL_TMR_W'(1);
          end
        end
        HS_ID_WAIT: begin
          if (link.rdata) begin
            ID_FOUND_O <= 1'b1;
            DONE_O     <= 1'b1;
            state      <= HS_IDLE;
          end else if (idx_rise && !idx_cnt) begin
            idx_cnt <= 1'b1;
          end else if (idx_rise) begin
            idx_cnt  <= 1'b0;
            BLOCKS_O <= BLOCKS_O + 8'(`STL_ID_BLOCKS);
            if ({1'b0, BLOCKS_O} + 9'(`STL_ID_BLOCKS) >=
                {1'b0, pos_goal}) begin
              DONE_O <= 1'b1;
              state  <= HS_IDLE;
            end
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end

endmodule // stl_ctrl

`default_nettype wire

// ---- bench/stl_link_checker.sv ----
/*
  Link checker: watches the wire and a few end ports.
  Assumes it is instantiated beside the link interface in the bench.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stl_cfg.svh"

module stl_link_checker #(
  parameter int GAP_CYC  = `STL_GAP_CYC,
  parameter int BUSY_CYC = `STL_BUSY_CYC
) (
  input wire logic                   CLK_I,        // Clock.
  input wire logic                   RST_I,        // Reset.
  input wire logic                   step,         // Step pulse.
  input wire logic                   dir_in,       // Direction.
  input wire logic                   busy,         // Drive busy.
  input wire logic                   index,        // Index pulse.
  input wire logic                   rdata,        // Header data.
  input wire logic                   track0,       // Track zero.
  input wire logic                   wprot,        // Write protect.
  input wire logic                   WPROT_I,      // Protect input.
  input wire logic                   HIGH_SPEED_I, // Fast tape.
  input wire logic                   BLOCK_MARK_I, // Block start.
  input wire logic                   HEADER_I,     // Header bit.
  input wire logic                   CMD_VALID_O,  // Train decoded.
  input wire stl_pkg::stl_track_type CMD_COUNT_O,  // Train length.
  input wire logic                   DONE_O,       // Done pulse.
  input wire logic                   ERR_O,        // Error pulse.
  input wire stl_pkg::stl_track_type SHADOW_O      // Shadow track.
);
  import stl_pkg::*;
  logic [19:0] since;
  logic [19:0] busy_run;

  // ====================
  // Cycle counters
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      since <= '0;
    end else if (step) begin
      since <= '0;
    end else if (since != 20'hfffff) begin
      since <= since + 20'h00001;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      busy_run <= '0;
    end else begin
      busy_run <= busy ? busy_run + 20'h00001 : 20'h00000;
    end
  end

  // ====================
  // Properties
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_index_follow: assert property (1'b1 |=> index == $past(BLOCK_MARK_I))
    else $error("index does not follow block mark");
  a_rdata_muted: assert property (HIGH_SPEED_I |=> !rdata)
    else $error("read data at high speed");
  a_rdata_header: assert property (HEADER_I && !HIGH_SPEED_I |=> rdata)
    else $error("header not passed on");
  a_step_single: assert property (step |=> !step [*8])
    else $error("steps too close");
  a_dir_steady: assert property (step |=> $stable(dir_in) [*8])
    else $error("direction moved within train");
  a_valid_busy: assert property (CMD_VALID_O |-> busy)
    else $error("no busy with decoded train");
  a_valid_gap: assert property (CMD_VALID_O |->
    since >= GAP_CYC - 3 && since <= GAP_CYC + 1)
    else $error("train decoded at wrong time");
  a_busy_span: assert property ($fell(busy) |-> busy_run == BUSY_CYC)
    else $error("busy length wrong");
  a_recal_track: assert property (CMD_VALID_O && CMD_COUNT_O == 7'h01
    |-> ##[0:1] track0)
    else $error("track zero not set");
  a_wprot_follow: assert property (1'b1 |=> wprot == $past(WPROT_I))
    else $error("write protect does not follow input");
  a_err_done: assert property (ERR_O |-> DONE_O)
    else $error("error without done");
  a_shadow_range: assert property (SHADOW_O <= 7'h4d)
    else $error("shadow out of range");

  c_train: cover property (CMD_VALID_O);
  c_err: cover property (ERR_O);
  c_header: cover property (rdata);
endmodule // stl_link_checker

`default_nettype wire

// ---- bench/stl_bench.sv ----
/*
  Self-checking bench: both link ends face each other on one interface.
  Assumes package, header, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module stl_bench;
  import stl_pkg::*;
  localparam int GAP = 25010;
  localparam int BSY = 30;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [6:0]    st = '0;
  logic          hs = 1'b0, mark = 1'b0, hdr = 1'b0, wp = 1'b0;
  stl_track_type pul = 7'h00;
  logic [7:0]    pos = 8'h00;
  logic          saw_err, done, err, bstat, t0, wpo, idf, sl, dma, cval;
  logic [7:0]    blk;
  stl_track_type shd, cnt;
  logic [6:0]    hl;
  logic [3:0]    hul;
  int            bad_count = 0, compares = 0, steps = 0, cyc = 0, last = 0;
  stl_link_if lnk ();

  stl_drive #(.GAP_CYC(GAP), .BUSY_CYC(BSY)) u_stl_drive (
    .CLK_I(clk), .RST_I(rst), .link(lnk), .HIGH_SPEED_I(hs),
    .BLOCK_MARK_I(mark), .HEADER_I(hdr), .WPROT_I(wp),
    .CMD_VALID_O(cval), .CMD_COUNT_O(cnt));
  stl_ctrl #(.GAP_CYC(GAP), .BUSY_CYC(BSY)) u_stl_ctrl (
    .CLK_I(clk), .RST_I(rst), .link(lnk), .CFG_LOAD_I(st[0]),
    .STEP_MS_I(4'h1), .HEAD_LOAD_I(7'h2a), .HEAD_UNLOAD_I(4'h5),
    .DMA_MODE_I(1'b0), .CMD_I(st[1]), .REPORT_I(st[2]),
    .CMD_PULSES_I(pul), .RECAL_I(st[3]), .EXT_CHANGE_I(st[4]),
    .ID_READ_I(st[5]), .POS_BLOCKS_I(pos), .SENSE_I(st[6]),
    .DONE_O(done), .ERR_O(err), .BUSY_STAT_O(bstat), .TRACK0_O(t0),
    .WPROT_O(wpo), .ID_FOUND_O(idf), .BLOCKS_O(blk), .SHADOW_O(shd),
    .HEAD_LOAD_O(hl), .HEAD_UNLOAD_O(hul), .DMA_MODE_O(dma),
    .SYNC_LOST_O(sl));
  stl_link_checker #(.GAP_CYC(GAP), .BUSY_CYC(BSY)) u_stl_link_checker (
    .CLK_I(clk), .RST_I(rst), .step(lnk.step), .dir_in(lnk.dir_in),
    .busy(lnk.busy), .index(lnk.index), .rdata(lnk.rdata),
    .track0(lnk.track0), .wprot(lnk.wprot), .WPROT_I(wp),
    .HIGH_SPEED_I(hs), .BLOCK_MARK_I(mark),
    .HEADER_I(hdr), .CMD_VALID_O(cval), .CMD_COUNT_O(cnt),
    .DONE_O(done), .ERR_O(err), .SHADOW_O(shd));

  // ====================
  // Clock, step log and shared tasks
  always #20 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (lnk.step === 1'b1) begin
      steps++;
      last = cyc;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Strobes for one cycle, then waits for the done pulse.
  task automatic run(input int b, input int lim);
    saw_err = 1'b0;
    @(negedge clk);
    st[b] = 1'b1;
    repeat (lim) begin
      @(posedge clk);
      #1;
      if (err === 1'b1) saw_err = 1'b1;
      if (done === 1'b1) break;
      @(negedge clk);
      st = '0;
    end
    chk(done, 1'b1);
    @(negedge clk);
    st = '0;
  endtask

  // ====================
  // Scenarios
  task automatic t_cfg();
    chk(dma, 1'b1);
    chk(hl, 7'h01);
    chk(hul, 4'h1);
    run(0, 4);
    chk(hl, 7'h2a);
    chk(hul, 4'h5);
    chk(dma, 1'b0);
    $display("test cfg finished");
  endtask

  task automatic t_id();
    fork
      run(5, 20);
      begin
        repeat (3) @(negedge clk);
        hdr = 1'b1;
        @(negedge clk);
        hdr = 1'b0;
      end
    join
    chk(idf, 1'b1);
    hs = 1'b1;
    hdr = 1'b1;
    pos = 8'h04;
    fork
      run(5, 60);
      repeat (4) begin
        repeat (4) @(negedge clk);
        mark = 1'b1;
        @(negedge clk);
        mark = 1'b0;
      end
    join
    chk(idf, 1'b0);
    chk(blk, 8'h04);
    hs = 1'b0;
    hdr = 1'b0;
    $display("test id finished");
  endtask

  task automatic t_refuse();
    int n;
    n = steps;
    pul = 7'h27;
    run(1, 4);
    chk(saw_err, 1'b1);
    chk(shd, 7'h00);
    @(negedge clk);
    st[4] = 1'b1;
    @(negedge clk);
    st[4] = 1'b0;
    pul = 7'h02;
    run(1, 4);
    chk(saw_err, 1'b1);
    chk(sl, 1'b1);
    chk(8'(steps - n), 8'h00);
    $display("test refuse finished");
  endtask

  task automatic t_recal();
    run(3, GAP + 40);
    chk(saw_err, 1'b0);
    chk(bstat, 1'b1);
    chk(shd, 7'h00);
    chk(sl, 1'b0);
    @(negedge clk);
    chk(cnt, 7'h01);
    chk(lnk.track0, 1'b1);
    wp = 1'b1;
    repeat (3) @(negedge clk);
    run(6, 4);
    chk(t0, 1'b1);
    chk(wpo, 1'b1);
    $display("test recal finished");
  endtask

  task automatic t_report();
    int n;
    n = steps;
    pul = 7'h02;
    run(2, GAP + 100);
    chk(saw_err, 1'b0);
    chk(8'(cyc - last + 1), 8'(BSY));
    chk(bstat, 1'b0);
    chk(shd, 7'h02);
    chk(lnk.dir_in, 1'b1);
    chk(8'(steps - n), 8'h02);
    repeat (GAP) begin
      @(posedge clk);
      #1;
      if (cval === 1'b1) break;
    end
    chk(cval, 1'b1);
    chk(cnt, 7'h02);
    $display("test report finished");
  endtask

  // A one-pulse plain command ends with its only step.
  task automatic t_plain();
    pul = 7'h01;
    run(1, 4);
    chk(saw_err, 1'b0);
    chk(lnk.step, 1'b1);
    chk(lnk.dir_in, 1'b1);
    chk(shd, 7'h03);
    $display("test plain finished");
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_cfg();
    t_id();
    t_refuse();
    t_recal();
    t_report();
    t_plain();
    close_out();
  end

  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out();
  end
endmodule // stl_bench

`default_nettype wire
